// >>> logic/smbc_slave.v
/*
  SMBus-compatible configuration slave: byte and block reads and writes
  into a small register bank; drives four differential output enables.
  Assumes serial clock and data are synchronous to i_clk and change
  slowly against it (at least four i_clk cycles per bus phase).
*/
// Contract
// - Answer only to address byte D2h, direction bit excluded from the compare.
// - Support byte write, byte read, block write and block read.
// - Command bit 7 zero selects block transfer, one selects byte transfer.
// - Byte transfers take register index from command bits 6..0; block uses zero.
// - Block transfers ascend by index, MSB first, may stop after any byte.
// - Block write: command, byte count, data bytes, each acknowledged, then stop.
// - Block read: after repeated start and read address, return count then data.
// - Byte write: command then one data byte into the indexed register.
// - Byte read: after repeated start return one data byte, then NACK, stop.
// - All registers take their default values at power-up.
// - Register 1 bits 2 and 0 enable outputs 0 and 1, default on.
// - Register 2 bits 7 and 6 enable outputs 2 and 3, default on.
// - Register 0 is reserved read-write, reset zero.
// - Byte count register, default 7, limits bytes returned by a block read.
`timescale 1ns/1ps
`include "smbc_consts.vh"

module smbc_slave (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_reset_n,
  // Serial bus
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  // Output enables
  output reg        o_diff_out0_enable,
  output reg        o_diff_out1_enable,
  output reg        o_diff_out2_enable,
  output reg        o_diff_out3_enable
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_CMD  = 3'h2;
  localparam ST_WCNT = 3'h3;
  localparam ST_WDAT = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_IGN  = 3'h6;

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus edge and condition detection
  reg  scl_q;
  reg  sda_q;
  wire scl_rise = i_scl & ~scl_q;
  wire scl_fall = ~i_scl & scl_q;
  wire start_c  = scl_q & i_scl & sda_q & ~i_sda;
  wire stop_c   = scl_q & i_scl & ~sda_q & i_sda;

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  reg  [2:0] st_q;
  reg  [3:0] bit_q;
  reg  [7:0] sh_q;
  reg        ack_q;
  reg        bmode_q;
  reg  [6:0] idx_q;
  reg  [7:0] left_q;
  reg        txm_q;
  reg        wr_q;
  reg  [7:0] wdata_q;
  reg  [6:0] widx_q;
  reg        first_q;
  reg        ld_q;

  wire [7:0] rd_data;
  wire [7:0] oe_low;
  wire [7:0] oe_high;
  wire [7:0] blen;

  smbc_regmem u_regs (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n_q),
    .i_wr_en   (wr_q),
    .i_wr_idx  (widx_q),
    .i_wr_data (wdata_q),
    .i_rd_idx  (idx_q),
    .o_rd_data (rd_data),
    .o_oe_low  (oe_low),
    .o_oe_high (oe_high),
    .o_blen    (blen)
  );

  localparam [7:0] SLAVE_ADDR = `SMBC_SLAVE_ADDR;

  // Open-drain drive for the leading bit of a byte: enable pulls low
  function pull_low;
    input [7:0] b;
    begin
      pull_low = ~b[7];
    end
  endfunction

  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      st_q      <= ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      ack_q     <= 1'b0;
      bmode_q   <= 1'b0;
      idx_q     <= 7'h00;
      left_q    <= 8'h00;
      txm_q     <= 1'b0;
      wr_q      <= 1'b0;
      wdata_q   <= 8'h00;
      widx_q    <= 7'h00;
      first_q   <= 1'b0;
      ld_q      <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe  <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      wr_q  <= 1'b0;
      ld_q  <= 1'b0;
      if (stop_c) begin
        st_q     <= ST_IDLE;
        ack_q    <= 1'b0;
        txm_q    <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (start_c) begin
        st_q     <= ST_ADDR;
        bit_q    <= 4'h0;
        ack_q    <= 1'b0;
        txm_q    <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (txm_q) begin
        // Transmit side: data bits, then the controller's answer
        if (ack_q) begin
          if (scl_rise && sda_q) begin
            st_q  <= ST_IGN;
            txm_q <= 1'b0;
            ack_q <= 1'b0;
          end else if (scl_fall || ld_q) begin
            ack_q <= 1'b0;
            bit_q <= 4'h0;
            if (first_q) begin
              sh_q     <= left_q;
              o_sda_oe <= pull_low(left_q);
              first_q  <= 1'b0;
            end else if (left_q == 8'h00) begin
              st_q     <= ST_IGN;
              txm_q    <= 1'b0;
              o_sda_oe <= 1'b0;
            end else begin
              sh_q     <= rd_data;
              o_sda_oe <= pull_low(rd_data);
              idx_q    <= idx_q + 7'h01;
              left_q   <= left_q - 8'h01;
            end
          end
        end else if (scl_rise) begin
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall) begin
          if (bit_q == 4'h8) begin
            ack_q    <= 1'b1;
            o_sda_oe <= 1'b0;
          end else begin
            o_sda_oe <= pull_low({sh_q[6:0], 1'b1});
            sh_q     <= {sh_q[6:0], 1'b1};
          end
        end
      end else if (ack_q) begin
        // Slave acknowledge lasts until the next falling edge
        if (scl_fall) begin
          bit_q <= 4'h0;
          if (st_q == ST_RDAT) begin
            txm_q <= 1'b1;
            ld_q  <= 1'b1;
          end else begin
            ack_q    <= 1'b0;
            o_sda_oe <= 1'b0;
          end
        end
      end else if (st_q != ST_IDLE && st_q != ST_IGN) begin
        if (scl_rise) begin
          sh_q  <= {sh_q[6:0], sda_q};
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall && bit_q == 4'h8) begin
          ack_q    <= 1'b1;
          o_sda_oe <= 1'b1;
          case (st_q)
            ST_ADDR: begin
              if (sh_q[7:1] == SLAVE_ADDR[7:1]) begin
                if (sh_q[0]) begin
                  st_q    <= ST_RDAT;
                  first_q <= ~bmode_q;
                  left_q  <= bmode_q ? 8'h01 : blen;
                end else begin
                  st_q <= ST_CMD;
                end
              end else begin
                st_q     <= ST_IDLE;
                o_sda_oe <= 1'b0;
                ack_q    <= 1'b0;
              end
            end
            ST_CMD: begin
              bmode_q <= sh_q[`SMBC_CMD_BYTE_BIT];
              idx_q   <= sh_q[`SMBC_CMD_BYTE_BIT] ? sh_q[6:0] : 7'h00;
              st_q    <= sh_q[`SMBC_CMD_BYTE_BIT] ? ST_WDAT : ST_WCNT;
            end
            ST_WCNT: begin
              st_q <= ST_WDAT;
            end
            ST_WDAT: begin
              wr_q    <= 1'b1;
              wdata_q <= sh_q;
              widx_q  <= idx_q;
              idx_q   <= idx_q + 7'h01;
            end
            default: begin
              o_sda_oe <= 1'b0;
              ack_q    <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output enables from registers
  always @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_diff_out0_enable <= 1'b1;
      o_diff_out1_enable <= 1'b1;
      o_diff_out2_enable <= 1'b1;
      o_diff_out3_enable <= 1'b1;
    end else begin
      o_diff_out0_enable <= oe_low[`SMBC_OUT0_BIT];
      o_diff_out1_enable <= oe_low[`SMBC_OUT1_BIT];
      o_diff_out2_enable <= oe_high[`SMBC_OUT2_BIT];
      o_diff_out3_enable <= oe_high[`SMBC_OUT3_BIT];
    end
  end

endmodule // smbc_slave

// >>> logic/smbc_consts.vh
/*
  Constants of the serial configuration slave: address, register indices,
  reset values, field positions and identification fields.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef SMBC_CONSTS_VH
`define SMBC_CONSTS_VH

// Slave address, eight-bit form with the direction bit clear
`define SMBC_SLAVE_ADDR      8'hD2
// Command code fields
`define SMBC_CMD_BYTE_BIT    7
// Register indices
`define SMBC_IDX_RSVD0       3'h0
`define SMBC_IDX_OE_LOW      3'h1
`define SMBC_IDX_OE_HIGH     3'h2
`define SMBC_IDX_ID          3'h3
`define SMBC_IDX_BLEN        3'h4
`define SMBC_NUM_REGS        5
// Reset values
`define SMBC_RST_RSVD0       8'h00
`define SMBC_RST_OE_LOW      8'h05
`define SMBC_RST_OE_HIGH     8'hC0
`define SMBC_RST_BLEN        8'h07
// Field positions
`define SMBC_OUT0_BIT        2
`define SMBC_OUT1_BIT        0
`define SMBC_OUT2_BIT        7
`define SMBC_OUT3_BIT        6
// Identification fields (values arbitrary)
`define SMBC_REV_CODE        4'h1
`define SMBC_MAKER_ID        4'h5

`endif

// >>> logic/smbc_regmem.v
/*
  Register bank of the configuration slave: five byte registers with a
  registered read port and a write port. Index 3 reads identification
  and ignores writes. Unmapped indices read zero and ignore writes.
  Assumes one clock and an already synchronised active-low reset.
*/
`timescale 1ns/1ps
`include "smbc_consts.vh"

module smbc_regmem (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Write port
  input  wire       i_wr_en,
  input  wire [6:0] i_wr_idx,
  input  wire [7:0] i_wr_data,
  // Read port
  input  wire [6:0] i_rd_idx,
  output reg  [7:0] o_rd_data,
  // Control fields
  output wire [7:0] o_oe_low,
  output wire [7:0] o_oe_high,
  output wire [7:0] o_blen
);

  reg [7:0] rsvd0_q;
  reg [7:0] oe_low_q;
  reg [7:0] oe_high_q;
  reg [7:0] blen_q;

  assign o_oe_low  = oe_low_q;
  assign o_oe_high = oe_high_q;
  assign o_blen    = blen_q;

  ////////////////////////////////////////////////////////////////////////
  // Writes
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsvd0_q   <= `SMBC_RST_RSVD0;
      oe_low_q  <= `SMBC_RST_OE_LOW;
      oe_high_q <= `SMBC_RST_OE_HIGH;
      blen_q    <= `SMBC_RST_BLEN;
    end else if (i_wr_en) begin
      case (i_wr_idx)
        {4'h0, `SMBC_IDX_RSVD0}:   rsvd0_q   <= i_wr_data;
        {4'h0, `SMBC_IDX_OE_LOW}:  oe_low_q  <= i_wr_data;
        {4'h0, `SMBC_IDX_OE_HIGH}: oe_high_q <= i_wr_data;
        {4'h0, `SMBC_IDX_BLEN}:    blen_q    <= i_wr_data;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered read
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      case (i_rd_idx)
        {4'h0, `SMBC_IDX_RSVD0}:   o_rd_data <= rsvd0_q;
        {4'h0, `SMBC_IDX_OE_LOW}:  o_rd_data <= oe_low_q;
        {4'h0, `SMBC_IDX_OE_HIGH}: o_rd_data <= oe_high_q;
        {4'h0, `SMBC_IDX_ID}:      o_rd_data <= {`SMBC_REV_CODE, `SMBC_MAKER_ID};
        {4'h0, `SMBC_IDX_BLEN}:    o_rd_data <= blen_q;
        default:                   o_rd_data <= 8'h00;
      endcase
    end
  end

endmodule // smbc_regmem

// >>> dv/smbc_props.sv
/* Checker on the slave's ports.
   Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
module smbc_props (
  // Clock, reset and bus
  input wire i_clk,
  input wire i_reset_n,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  // Output enables
  input wire o_diff_out0_enable,
  input wire o_diff_out1_enable,
  input wire o_diff_out2_enable,
  input wire o_diff_out3_enable
);
  reg        scl_q;
  reg  [7:0] idle_q;
  wire [3:0] en = {o_diff_out0_enable, o_diff_out1_enable,
                   o_diff_out2_enable, o_diff_out3_enable};
  ////////////////////////////////////////////////////////////////
  // Clocks since the serial clock last moved
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_q  <= 1'b1;
      idle_q <= 8'h00;
    end else begin
      scl_q  <= i_scl;
      idle_q <= (i_scl != scl_q) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_rst_def; $rose(i_reset_n) |-> en == 4'hF; endproperty
  a_rst_def: assert property (p_rst_def) else $error("enables off");
  property p_rst_quiet; $rose(i_reset_n) |-> !o_sda_oe [*3]; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("early drive");
  property p_drain; !o_sda_out; endproperty
  a_drain: assert property (p_drain) else $error("data driven high");
  property p_ack_go; $rose(o_sda_oe) |-> !i_scl; endproperty
  a_ack_go: assert property (p_ack_go) else $error("drive in high");
  property p_ack_end; $fell(o_sda_oe) |-> !i_scl; endproperty
  a_ack_end: assert property (p_ack_end) else $error("release in high");
  property p_ack_hold; $rose(o_sda_oe) |-> o_sda_oe [*4]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("short drive");
  property p_en_cause; $changed(en) |-> idle_q < 8'h3C; endproperty
  a_en_cause: assert property (p_en_cause) else $error("enable moved idle");
  property p_idle; o_sda_oe |-> idle_q < 8'h3C; endproperty
  a_idle: assert property (p_idle) else $error("drive on idle bus");
  c_ack: cover property ($rose(o_sda_oe));
  c_out0: cover property ($fell(o_diff_out0_enable));
  c_out2: cover property ($fell(o_diff_out2_enable));
endmodule // smbc_props
bind smbc_slave smbc_props smbc_props_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_diff_out0_enable(o_diff_out0_enable), .o_diff_out1_enable(o_diff_out1_enable),
  .o_diff_out2_enable(o_diff_out2_enable), .o_diff_out3_enable(o_diff_out3_enable));

// >>> dv/smbc_host_model.sv
/* Bus controller model: clocks the bus, pulls data low.
   Assumes a pull-up resolves the data wire. */
`timescale 1ns/1ps
module smbc_host_model (
  // Clock and bus
  input  wire i_clk,
  input  wire i_sda,
  output reg  o_scl = 1'b1,
  output reg  o_sda_low = 1'b0
);
  // One bus phase of eight clocks, then both lines
  task step(input c, input l);
    repeat (8) @(posedge i_clk);
    #1;
    o_scl = c;
    o_sda_low = l;
  endtask
  // Start and repeated start
  task start;
    step(o_scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task stop;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
  endtask
  task bitx(input b, output r);
    step(1'b0, !b);
    step(1'b1, !b);
    repeat (8) @(posedge i_clk);
    #1;
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // Byte out, MSB first; acknowledge seen as low
  task wr(input [7:0] v, output a);
    reg r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    a = !r;
  endtask
  // Byte in; last byte answered with not-acknowledge
  task rd(input last, output [7:0] v);
    reg r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(last, r);
  endtask
endmodule // smbc_host_model

// >>> dv/smbus_config_register_slave_tb.sv
/* Bench of the configuration slave through the host model.
   Assumes the model and checker compile first. */
`timescale 1ns/1ps
`include "smbc_consts.vh"
`define H smbc_host_model_i
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module smbus_config_register_slave_tb;
  reg        i_clk = 1'b0;
  reg        i_reset_n = 1'b0;
  wire       scl;
  wire       sda_low;
  wire       sda_out;
  wire       sda_oe;
  wire [3:0] en;
  reg  [7:0] d;
  reg  [5:0] ak;
  int        fail_count = 0;
  int        samples_checked = 0;
  wire       sda = !(sda_low || (sda_oe && !sda_out));
  smbc_slave smbc_slave_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_diff_out0_enable(en[3]),
    .o_diff_out1_enable(en[2]), .o_diff_out2_enable(en[1]), .o_diff_out3_enable(en[0]));
  smbc_host_model smbc_host_model_i (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  initial forever #20 i_clk = !i_clk;
  ////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wreg(input [7:0] c, input [7:0] v);
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR, ak[0]);
    `H.wr(c, ak[1]);
    `H.wr(v, ak[2]);
    `H.stop;
    `CHK("wr_ack", 3'h7, ak[2:0])
  endtask
  task rreg(input [7:0] c, output [7:0] v);
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR, ak[0]);
    `H.wr(c, ak[1]);
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR | 8'h01, ak[2]);
    `H.rd(1'b1, v);
    `H.stop;
    `CHK("rd_ack", 3'h7, ak[2:0])
  endtask
  ////////////////////////////////////////////////////////////////
  task t_defaults;
    reg [39:0] exp;
    exp = {`SMBC_RST_RSVD0, `SMBC_RST_OE_LOW, `SMBC_RST_OE_HIGH,
           `SMBC_REV_CODE, `SMBC_MAKER_ID, `SMBC_RST_BLEN};
    `CHK("en", 4'hF, en)
    for (int i = 0; i < 5; i++) begin
      rreg(8'h80 | i[7:0], d);
      `CHK("dflt", exp[39 - 8 * i -: 8], d)
    end
  endtask
  task t_byte;
    wreg(8'h81, 8'h00);
    `CHK("en_low", 4'h3, en)
    wreg(8'h82, 8'h40);
    `CHK("en_high", 4'h1, en)
    rreg(8'h82, d);
    `CHK("reg2", 8'h40, d)
    wreg(8'h83, 8'hFF);
    rreg(8'h83, d);
    `CHK("id", {`SMBC_REV_CODE, `SMBC_MAKER_ID}, d)
  endtask
  task t_blk_w;
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR, ak[0]);
    `H.wr(8'h00, ak[1]);
    `H.wr(8'h03, ak[2]);
    `H.wr(8'h5A, ak[3]);
    `H.wr(`SMBC_RST_OE_LOW, ak[4]);
    `H.wr(`SMBC_RST_OE_HIGH, ak[5]);
    `H.stop;
    `CHK("blk_ack", 6'h3F, ak)
    `CHK("blk_en", 4'hF, en)
  endtask
  task t_bad;
    `H.start;
    `H.wr(8'hD4, ak[0]);
    `H.wr(8'h81, ak[1]);
    `H.wr(8'h00, ak[2]);
    `H.stop;
    `CHK("foreign", 4'h1, {ak[2:0], en == 4'hF})
  endtask
  task t_blk_r;
    wreg(8'h84, 8'h02);
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR, ak[0]);
    `H.wr(8'h00, ak[1]);
    `H.start;
    `H.wr(`SMBC_SLAVE_ADDR | 8'h01, ak[2]);
    `CHK("blkr_ack", 3'h7, ak[2:0])
    `H.rd(1'b0, d);
    `CHK("count", 8'h02, d)
    `H.rd(1'b0, d);
    `CHK("blk0", 8'h5A, d)
    `H.rd(1'b1, d);
    `H.stop;
    `CHK("blk1", `SMBC_RST_OE_LOW, d)
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    fail_count++;
    results;
  end
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    repeat (4) @(posedge i_clk);
    t_defaults;
    t_byte;
    t_blk_w;
    t_bad;
    t_blk_r;
    results;
  end
endmodule // smbus_config_register_slave_tb
